/* verilog/fppc_pkg.sv */
`default_nettype none
package fppc_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PROG_TIME_NS = 6800000;
  localparam int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 17;
  // page addressing: sector and page folded into one index
  localparam int unsigned PAGE_W = 6;
  localparam int unsigned PAGES = 64;
  localparam int unsigned WCNT_W = 16;
  localparam logic [15:0] WRITE_THRESHOLD = 16'h03E8;
  // register byte offsets
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_BUF = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h0C;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
  // command register fields
  localparam int unsigned CMD_PROG_BIT = 0;
  localparam int unsigned CMD_ERASE_BIT = 1;
  localparam int unsigned CMD_REDIR_BIT = 2;
  localparam int unsigned CMD_LOCK_BIT = 3;
  localparam int unsigned CMD_ADDR_LSB = 8;
  // buffer register fields
  localparam int unsigned BUF_ADDR_LSB = 0;
  localparam int unsigned BUF_MOD_BIT = 8;
  localparam int unsigned BUF_PLP_BIT = 9;
  // status register fields
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_CODE_LSB = 1;
  localparam int unsigned STAT_ADDR_LSB = 8;
  // interrupt status bits
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_ERR_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  // outcome codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_REFUSED = 2'h1;
  localparam logic [1:0] ST_ECC = 2'h2;
  localparam logic [1:0] ST_WEAR = 2'h3;

  typedef struct packed {
    logic erase;
    logic redirect;
    logic lock;
    logic [PAGE_W-1:0] addr;
  } fppc_cmd_t;

  typedef struct packed {
    logic [PAGE_W-1:0] addr;
    logic modified;
    logic plp;
  } fppc_buf_t;
endpackage : fppc_pkg
`default_nettype wire

/* verilog/fppc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module fppc_timer #(
  parameter int unsigned CYCLES = fppc_pkg::PROG_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  output logic running,
  output logic done
);
  logic [fppc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic run_reg, run_next;
  logic done_reg, done_next;

  // count down the array write time, pulse done in the cycle after the last
  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    done_next = 1'b0;
    if (start && !run_reg) begin
      cnt_next = fppc_pkg::CNT_W'(CYCLES - 1);
      run_next = 1'b1;
    end else if (run_reg) begin
      if (cnt_reg == '0) begin
        run_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      done_reg <= done_next;
    end
  end

  assign running = run_reg;
  assign done = done_reg;
endmodule : fppc_timer
`default_nettype wire

/* verilog/fppc_check.sv */
`timescale 1ns/1ps
`default_nettype none
module fppc_check (
  input var fppc_pkg::fppc_cmd_t cmd,
  input var fppc_pkg::fppc_buf_t buf_state,
  input wire logic target_locked,
  output logic refuse
);
  logic mismatch;

  // decide whether a request is turned away before any array write
  always_comb begin
    mismatch = cmd.addr != buf_state.addr;
    refuse = 1'b0;
    if (target_locked) begin
      refuse = 1'b1;
    end else if (cmd.erase) begin
      refuse = 1'b0;
    end else if (mismatch) begin
      // a foreign page is taken only on redirect without page-loss protection
      refuse = !cmd.redirect || buf_state.plp;
    end else begin
      refuse = !buf_state.modified;
    end
  end
endmodule : fppc_check
`default_nettype wire

/* verilog/fppc_top.sv */
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fppc_top #(
  parameter int unsigned PROG_CYCLES = fppc_pkg::PROG_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ecc_uncorrectable,
  output logic busy,
  output logic [1:0] status_code,
  output logic [5:0] array_page,
  output logic irq
);
  // expand byte enables into a bit mask
  function automatic logic [31:0] fppc_be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : fppc_be_mask

  // true when the bus request hits the given offset
  function automatic logic fppc_hit(input logic [4:0] a, input logic [4:0] ofs);
    return a == ofs;
  endfunction : fppc_hit

  // pack the status register word
  function automatic logic [31:0] fppc_stat_word(input logic b, input logic [1:0] c,
    input logic [5:0] p);
    logic [31:0] w;
    w = '0;
    w[fppc_pkg::STAT_BUSY_BIT] = b;
    w[fppc_pkg::STAT_CODE_LSB +: 2] = c;
    w[fppc_pkg::STAT_ADDR_LSB +: fppc_pkg::PAGE_W] = p;
    return w;
  endfunction : fppc_stat_word

  // pack the buffer register word
  function automatic logic [31:0] fppc_buf_word(input fppc_pkg::fppc_buf_t bs);
    logic [31:0] w;
    w = '0;
    w[fppc_pkg::BUF_ADDR_LSB +: fppc_pkg::PAGE_W] = bs.addr;
    w[fppc_pkg::BUF_MOD_BIT] = bs.modified;
    w[fppc_pkg::BUF_PLP_BIT] = bs.plp;
    return w;
  endfunction : fppc_buf_word

  // final code of a page write: wear beats an ecc failure
  function automatic logic [1:0] fppc_final_code(input logic worn, input logic ecc_bad);
    logic [1:0] c;
    c = fppc_pkg::ST_OK;
    if (ecc_bad) begin
      c = fppc_pkg::ST_ECC;
    end
    if (worn) begin
      c = fppc_pkg::ST_WEAR;
    end
    return c;
  endfunction : fppc_final_code

  typedef enum logic [1:0] {FPPC_IDLE, FPPC_WRITE, FPPC_REPORT} fppc_state_t;

  // bus handshake state
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic acc;
  logic wr_acc;
  logic [31:0] wmask;
  logic [31:0] wval;

  // software visible state
  fppc_pkg::fppc_buf_t buf_reg, buf_next;
  logic [1:0] irq_stat_reg, irq_stat_next;
  logic [1:0] irq_mask_reg, irq_mask_next;
  logic irq_reg, irq_next;

  // operation state
  fppc_state_t state_reg, state_next;
  fppc_pkg::fppc_cmd_t cmd_reg, cmd_next;
  fppc_pkg::fppc_cmd_t req_cmd;
  logic [1:0] code_reg, code_next;
  logic [5:0] page_reg, page_next;
  logic [fppc_pkg::PAGES-1:0] lock_reg, lock_next;
  logic req_prog, req_erase, req_any;
  logic refuse;
  logic timer_start;
  logic timer_run;
  logic timer_done;
  logic [1:0] ev_set;
  logic [fppc_pkg::WCNT_W-1:0] wcount [fppc_pkg::PAGES];
  logic wcount_bump;

  // access completing at this edge, and its lane-masked write data
  assign acc = (avs_read || avs_write) && !wait_reg;
  assign wr_acc = avs_write && !wait_reg;
  assign wmask = fppc_be_mask(avs_byteenable);
  assign wval = avs_writedata & wmask;

  // decode a command register write into a request
  always_comb begin
    req_prog = 1'b0;
    req_erase = 1'b0;
    if (wr_acc && fppc_hit(avs_address, fppc_pkg::OFS_CMD) && avs_byteenable[0]) begin
      req_prog = avs_writedata[fppc_pkg::CMD_PROG_BIT];
      req_erase = avs_writedata[fppc_pkg::CMD_ERASE_BIT] && !req_prog;
    end
    req_any = (req_prog || req_erase) && state_reg == FPPC_IDLE;
    req_cmd.erase = req_erase && !req_prog;
    // redirect and lock are only looked at along with a request
    req_cmd.redirect = req_any && avs_writedata[fppc_pkg::CMD_REDIR_BIT];
    req_cmd.lock = req_any && req_prog && avs_writedata[fppc_pkg::CMD_LOCK_BIT];
    req_cmd.addr = avs_writedata[fppc_pkg::CMD_ADDR_LSB +: fppc_pkg::PAGE_W];
  end

  fppc_check u_check (
    .cmd(req_cmd),
    .buf_state(buf_reg),
    .target_locked(lock_reg[req_cmd.addr]),
    .refuse(refuse)
  );

  fppc_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .start(timer_start),
    .running(timer_run),
    .done(timer_done)
  );

  // operation sequencer
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    code_next = code_reg;
    page_next = page_reg;
    lock_next = lock_reg;
    timer_start = 1'b0;
    wcount_bump = 1'b0;
    ev_set = 2'h0;
    unique case (state_reg)
      FPPC_IDLE: begin
        if (req_any) begin
          cmd_next = req_cmd;
          page_next = req_cmd.addr;
          if (refuse) begin
            code_next = fppc_pkg::ST_REFUSED;
            ev_set[fppc_pkg::IRQ_DONE_BIT] = 1'b1;
            ev_set[fppc_pkg::IRQ_ERR_BIT] = 1'b1;
          end else begin
            code_next = fppc_pkg::ST_OK;
            timer_start = 1'b1;
            state_next = FPPC_WRITE;
          end
        end
      end
      FPPC_WRITE: begin
        if (timer_done) begin
          state_next = FPPC_REPORT;
        end
      end
      FPPC_REPORT: begin
        // outcome is settled in the same edge that drops busy
        state_next = FPPC_IDLE;
        ev_set[fppc_pkg::IRQ_DONE_BIT] = 1'b1;
        if (cmd_reg.erase) begin
          code_next = fppc_pkg::ST_OK;
        end else begin
          wcount_bump = 1'b1;
          if (cmd_reg.lock) begin
            lock_next[cmd_reg.addr] = 1'b1;
          end
          // wear is judged on the count before this write
          code_next = fppc_final_code(wcount[cmd_reg.addr] >= fppc_pkg::WRITE_THRESHOLD,
            ecc_uncorrectable);
          if (code_next != fppc_pkg::ST_OK) begin
            ev_set[fppc_pkg::IRQ_ERR_BIT] = 1'b1;
          end
        end
      end
      default: begin
        state_next = FPPC_IDLE; // unused state code falls back to idle
      end
    endcase
  end

  // operation state registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= FPPC_IDLE;
      cmd_reg <= '0;
      code_reg <= fppc_pkg::ST_OK;
      page_reg <= '0;
      lock_reg <= '0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      code_reg <= code_next;
      page_reg <= page_next;
      lock_reg <= lock_next;
    end
  end

  // per-page write counters, bumped once per completed page write
  genvar gp;
  generate
    for (gp = 0; gp < fppc_pkg::PAGES; gp++) begin : g_wcount
      logic [fppc_pkg::WCNT_W-1:0] wc_next;
      // saturating count of this page's completed writes
      always_comb begin
        wc_next = wcount[gp];
        if (wcount_bump && cmd_reg.addr == fppc_pkg::PAGE_W'(gp) && wcount[gp] != '1) begin
          wc_next = wcount[gp] + 1'b1;
        end
      end
      // counter register of this page
      always_ff @(posedge clock) begin
        if (rst) begin
          wcount[gp] <= '0;
        end else begin
          wcount[gp] <= wc_next;
        end
      end
    end
  endgenerate

  // bus slave: one wait cycle, then the access completes
  always_comb begin
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    buf_next = buf_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg | ev_set;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      rdata_next = '0;
      if (avs_read) begin
        unique case (avs_address)
          fppc_pkg::OFS_BUF: rdata_next = fppc_buf_word(buf_reg);
          fppc_pkg::OFS_STAT: rdata_next = fppc_stat_word(timer_run || state_reg != FPPC_IDLE,
            code_reg, page_reg);
          fppc_pkg::OFS_IRQ_STATUS: rdata_next[1:0] = irq_stat_reg;
          fppc_pkg::OFS_IRQ_MASK: rdata_next[1:0] = irq_mask_reg;
          default: rdata_next = '0; // command and unmapped read as zero
        endcase
      end
    end
    if (acc && avs_read && fppc_hit(avs_address, fppc_pkg::OFS_IRQ_STATUS)) begin
      // clear only what was returned; a new event in this cycle survives
      irq_stat_next = (irq_stat_reg & ~rdata_reg[1:0]) | ev_set;
    end
    if (wr_acc && fppc_hit(avs_address, fppc_pkg::OFS_BUF)) begin
      if (avs_byteenable[0]) begin
        buf_next.addr = wval[fppc_pkg::BUF_ADDR_LSB +: fppc_pkg::PAGE_W];
      end
      if (avs_byteenable[1]) begin
        buf_next.modified = wval[fppc_pkg::BUF_MOD_BIT];
        buf_next.plp = wval[fppc_pkg::BUF_PLP_BIT];
      end
    end
    if (wr_acc && fppc_hit(avs_address, fppc_pkg::OFS_IRQ_MASK) && avs_byteenable[0]) begin
      irq_mask_next = wval[1:0];
    end
    // a finished write to the buffered page leaves the buffer clean
    if (state_reg == FPPC_REPORT && !cmd_reg.erase && cmd_reg.addr == buf_reg.addr) begin
      buf_next.modified = 1'b0;
    end
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  // bus handshake and register file state
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
      buf_reg <= '0;
      irq_stat_reg <= fppc_pkg::IRQ_RESET;
      irq_mask_reg <= fppc_pkg::IRQ_MASK_RESET;
      irq_reg <= 1'b0;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      buf_reg <= buf_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
    end
  end

  // busy mirrors the write phase, including the reporting cycle
  logic busy_reg, busy_next;
  always_comb begin
    busy_next = busy_reg;
    if (timer_start) begin
      busy_next = 1'b1;
    end else if (state_reg == FPPC_REPORT) begin
      busy_next = 1'b0;
    end
  end

  // busy register
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  // outputs come straight from their flip-flops
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign busy = busy_reg;
  assign status_code = code_reg;
  assign array_page = page_reg;
  assign irq = irq_reg;
endmodule : fppc_top
`default_nettype wire

/* verif/fppc_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module fppc_top_chk #(
  parameter int unsigned PROG_CYCLES = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ecc_uncorrectable,
  input wire logic busy,
  input wire logic [1:0] status_code,
  input wire logic [5:0] array_page,
  input wire logic irq
);
  int unsigned run_cnt_reg;
  int unsigned run_cnt_next;
  logic cmd_wr;
  logic cmd_go;
  // length of the current busy stretch
  always_comb begin
    run_cnt_next = busy ? run_cnt_reg + 1 : 0;
  end
  always_ff @(posedge clock) begin
    run_cnt_reg <= rst ? 0 : run_cnt_next;
  end
  // command write completing on the bus, and the same with a go bit while idle
  assign cmd_wr = avs_write && !avs_waitrequest && avs_address == 5'h00 && avs_byteenable[0];
  assign cmd_go = cmd_wr && (avs_writedata[0] || avs_writedata[1]) && !busy;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_go;
    cmd_go;
  endsequence
  sequence s_run;
    busy [*8];
  endsequence
  chk_wait_once:
  assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");
  chk_busy_hold:
  assert property ($rose(busy) |-> s_run) else $error("busy dropped early");
  chk_busy_len:
  // busy spans the timed write, the done pulse and the report cycle
  assert property ($fell(busy) |-> run_cnt_reg == PROG_CYCLES + 2)
    else $error("busy stretch has wrong length");
  chk_start_code:
  assert property ($rose(busy) |-> status_code == 2'h0) else $error("code not cleared at start");
  chk_code_hold:
  assert property ($changed(status_code) |-> $rose(busy) || $fell(busy) || $past(cmd_go))
    else $error("status code changed outside an operation edge");
  chk_go_answer:
  assert property (s_go |=> (busy && status_code == 2'h0) || (!busy && status_code == 2'h1))
    else $error("command neither started nor refused");
  chk_go_page:
  assert property (s_go |=> array_page == $past(avs_writedata[13:8]))
    else $error("target page not taken from command");
  chk_no_go:
  assert property (cmd_wr && avs_writedata[1:0] == 2'h0 && !busy |=> !busy)
    else $error("command without go bit started a write");
endmodule : fppc_top_chk
bind fppc_top fppc_top_chk #(.PROG_CYCLES(PROG_CYCLES)) i_fppc_top_chk (.clock(clock),
  .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ecc_uncorrectable(ecc_uncorrectable), .busy(busy), .status_code(status_code),
  .array_page(array_page), .irq(irq));
`default_nettype wire

/* verif/fppc_req_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fppc_req_model (
  input wire logic clock,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  output logic ecc_uncorrectable
);
  // idle bus at time zero
  initial begin
    avs_address = 5'h1F;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    ecc_uncorrectable = 1'b0;
  end
  // one access, held until waitrequest is seen low, then released
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clock);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a; // released lines show no stale value
    avs_writedata <= ~d;
  endtask : xfer
  // array check result for the next write
  task automatic set_ecc(input logic v);
    @(posedge clock);
    ecc_uncorrectable <= v;
  endtask : set_ecc
  // byte lanes for the following accesses
  task automatic set_be(input logic [3:0] be);
    @(posedge clock);
    avs_byteenable <= be;
  endtask : set_be
endmodule : fppc_req_model
`default_nettype wire

/* verif/fppc_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fppc_top_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic avs_read, avs_write, avs_waitrequest, ecc_uncorrectable, busy, irq, mask_on;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [3:0] avs_byteenable;
  logic [1:0] status_code;
  logic [5:0] array_page;
  bit locked [64];
  int wcount [64];
  int fails = 0;
  int n_compared = 0;
  int seed = 40;
  int cyc = 0;
  int r;
  // 10 MHz clock
  always #50 clock = ~clock;
  fppc_top #(.PROG_CYCLES(8)) i_fppc_top (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ecc_uncorrectable(ecc_uncorrectable), .busy(busy),
    .status_code(status_code), .array_page(array_page), .irq(irq));
  fppc_req_model i_fppc_req_model (.clock(clock), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .ecc_uncorrectable(ecc_uncorrectable));
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      $display("MISMATCH t=%0t timeout", $time);
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    i_fppc_req_model.xfer(1'b1, a, d, rdata);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    i_fppc_req_model.xfer(1'b0, a, 32'h0, rdata);
  endtask : rd
  // outcome of a write or erase from lock state, buffer state and wear
  function automatic logic [1:0] exp_code(input logic er, rw, input int t, b,
    input logic mf, pl, ec);
    if (locked[t]) return fppc_pkg::ST_REFUSED;
    if (er) return fppc_pkg::ST_OK;
    if (t != b && (!rw || pl)) return fppc_pkg::ST_REFUSED;
    if (t == b && !mf) return fppc_pkg::ST_REFUSED;
    if (wcount[t] >= int'(fppc_pkg::WRITE_THRESHOLD)) return fppc_pkg::ST_WEAR;
    if (ec) return fppc_pkg::ST_ECC;
    return fppc_pkg::ST_OK;
  endfunction : exp_code
  // one operation: set buffer, issue command, wait for the end, check the outcome
  task automatic op(input logic er, rw, lk, input int t, b, input logic mf, pl, ec);
    logic [1:0] e;
    e = exp_code(er, rw, t, b, mf, pl, ec);
    wr(fppc_pkg::OFS_BUF, {22'h0, pl, mf, 2'h0, b[5:0]});
    i_fppc_req_model.set_ecc(ec);
    wr(fppc_pkg::OFS_CMD, {18'h0, t[5:0], 4'h0, lk, rw, er, !er});
    @(posedge clock);
    for (int k = 0; k < 20 && busy === 1'b1; k++) @(posedge clock);
    chk(status_code, e);
    chk(array_page, t[5:0]);
    if (!er && e != fppc_pkg::ST_REFUSED) wcount[t]++;
    if (lk && e != fppc_pkg::ST_REFUSED) locked[t] = 1'b1;
    rd(fppc_pkg::OFS_STAT);
    chk(rdata, {18'h0, t[5:0], 5'h0, e, 1'b0});
    chk(irq, mask_on);
    rd(fppc_pkg::OFS_IRQ_STATUS);
    chk(rdata[1:0], {e != fppc_pkg::ST_OK, 1'b1});
    rd(fppc_pkg::OFS_IRQ_STATUS);
    chk({rdata[1:0], irq}, 3'h0);
    if (!er && t == b && e == fppc_pkg::ST_OK) begin
      rd(fppc_pkg::OFS_BUF);
      chk(rdata[9:8], {pl, 1'b0});
    end
  endtask : op
  // main sequence
  initial begin
    mask_on = 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(5'(4 * i));
      chk(rdata, 32'h0);
    end
    wr(5'h14, 32'hFFFF_FFFF);
    rd(5'h14);
    chk(rdata, 32'h0);
    wr(fppc_pkg::OFS_IRQ_MASK, 32'h3);
    rd(fppc_pkg::OFS_IRQ_MASK);
    chk(rdata, 32'h3);
    i_fppc_req_model.set_be(4'h1);
    wr(fppc_pkg::OFS_BUF, 32'h0000_0325);
    rd(fppc_pkg::OFS_BUF);
    chk(rdata, 32'h0000_0025);
    i_fppc_req_model.set_be(4'h2);
    wr(fppc_pkg::OFS_CMD, 32'h0000_0501);
    @(posedge clock);
    chk({busy, status_code}, 3'h0);
    i_fppc_req_model.set_be(4'hF);
    wr(fppc_pkg::OFS_CMD, 32'h0000_050C);
    @(posedge clock);
    chk({busy, status_code}, 3'h0);
    op(0, 1, 0, 5, 0, 1, 0, 0);
    op(0, 1, 1, 62, 0, 1, 0, 0);
    op(0, 1, 0, 62, 0, 1, 0, 0);
    op(1, 0, 0, 62, 0, 1, 0, 0);
    op(0, 0, 0, 62, 62, 1, 0, 0);
    op(0, 0, 0, 10, 10, 1, 0, 1);
    op(0, 0, 0, 10, 10, 0, 0, 0);
    op(0, 1, 0, 3, 2, 1, 1, 0);
    op(0, 0, 0, 3, 2, 0, 0, 0);
    wr(fppc_pkg::OFS_IRQ_MASK, 32'h0);
    mask_on = 1'b0;
    op(1, 0, 0, 1, 0, 0, 0, 0);
    wr(fppc_pkg::OFS_IRQ_MASK, 32'h3);
    mask_on = 1'b1;
    repeat (40) begin
      r = $random(seed);
      op(r[0], r[1], 1'b0, r[3:2], r[5:4], r[6], r[7], r[8] & r[9]);
    end
    repeat (1001) op(1'b0, 1'b1, 1'b0, 63, 0, 1'b1, 1'b0, 1'b0);
    print_verdict();
  end
endmodule : fppc_top_tb_top
`default_nettype wire
